// ---- hw/rrs_regs.vh ----
`ifndef RRS_REGS_VH
`define RRS_REGS_VH
// Register byte offsets
`define RRS_CTRL_OFF 12'h000
`define RRS_STATUS_OFF 12'h004
`define RRS_BASE_OFF 12'h008
`define RRS_DOFF_OFF 12'h00C
`define RRS_DDATA_OFF 12'h010
`define RRS_ERR_OFF 12'h014
`define RRS_IRQ_ST_OFF 12'h018
`define RRS_IRQ_MASK_OFF 12'h01C
`define RRS_CHTYPE_OFF 12'h020
// Control fields
`define RRS_CTRL_START 0
`define RRS_CTRL_WRITE 1
`define RRS_CTRL_MODE_LO 2
`define RRS_CTRL_MODE_HI 3
`define RRS_CTRL_ADDRMODE 4
`define RRS_CTRL_CLRERR 5
`define RRS_MODE_STREAM 2'h0
`define RRS_MODE_DIRECT 2'h1
// Record fields
`define RRS_LEN_HI 15
`define RRS_LEN_LO 11
`define RRS_OP_HI 4
`define RRS_OP_LO 0
`define RRS_OFF_HI 10
`define RRS_OFF_LO 0
`define RRS_CHT_HI 7
`define RRS_CHT_LO 5
// Operation codes
`define RRS_OP_START 5'h01
`define RRS_OP_CHTYPE 5'h02
`define RRS_OP_REFCLK 5'h03
`define RRS_OP_CLOCK_GEN_BLOCK_SWITCH 5'h04
`define RRS_OP_END 5'h1F
// Channel type codes
`define RRS_CHT_DUPLEX 3'h0
`define RRS_CHT_CHANNEL_UNIT_PLL 3'h1
`define RRS_CHT_RX_ONLY 3'h2
`define RRS_CHT_TX_ONLY 3'h3
`define RRS_CHT_AUXILIARY_TX_PLL 3'h4
// Event bits and control reset value
`define RRS_EV_DONE 0
`define RRS_EV_ERR 1
`define RRS_CTRL_RST 32'h00000000
`endif

// ---- hw/rrs_sync2.v ----
`timescale 1ns/100ps
`default_nettype none
module rrs_sync2 (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire d,
  output reg q
);
  reg meta_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- hw/rrs_streamer.v ----
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "rrs_regs.vh"
// Overview of operation
// R1 - Mode field 01 selects direct write
// R2 - Direct write touches only addressed location
// R3 - Image memory sits on fetch port
// R4 - Every image entry is one 16-bit word
// R5 - Bits 15:11 length; zero means command
// R6 - Command opcode in bits 4:0
// R7 - Decode start, type, refclk, clockgen, end
// R8 - Channel type is a 3-bit code
// R9 - Header bits 10:0 give logical offset
// R10 - Consume exactly length data words after header
// R11 - Data words go to consecutive offsets
// R12 - Image holds fixed leading commands, end last
// R13 - Bad opcode or bad first entry flags error; a first entry with nonzero length is taken as a data header and not flagged
// R14 - Start bit launches stream, self clears
// R15 - Recorded error blocks streaming until cleared
// R16 - Address mode 0 bytes, 1 words
// R17 - End command stops fetch, drops busy
module rrs_streamer (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg [31:0] img_addr,
  output reg img_rd,
  input wire [15:0] img_rdata,
  input wire img_rvalid,
  output reg [10:0] xcvr_offset,
  output reg [31:0] xcvr_wdata,
  output reg xcvr_wr,
  input wire xcvr_wait_async,
  output reg busy,
  output reg irq
);
  localparam S_IDLE = 3'h0;
  localparam S_FETCH = 3'h1;
  localparam S_WAIT = 3'h2;
  localparam S_DECODE = 3'h3;
  localparam S_WRITE = 3'h4;
  localparam S_DIRECT = 3'h5;
  reg [2:0] state_reg;
  reg [1:0] mode_reg;
  reg addr_mode_reg;
  reg [31:0] base_reg;
  reg [10:0] doff_reg;
  reg [31:0] ddata_reg;
  reg opcode_err_reg;
  reg [1:0] irq_st_reg;
  reg [1:0] irq_mask_reg;
  reg [2:0] chtype_reg;
  reg [15:0] word_reg;
  reg [4:0] remain_reg;
  reg [10:0] woff_reg;
  reg first_reg;
  reg direct_req_reg;
  wire xcvr_wait;
  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pwrite && pready;
  wire start_hit = wr_acc && (paddr == `RRS_CTRL_OFF) && pwdata[`RRS_CTRL_START];
  wire write_hit = wr_acc && (paddr == `RRS_CTRL_OFF) && pwdata[`RRS_CTRL_WRITE];
  wire clr_hit = wr_acc && (paddr == `RRS_CTRL_OFF) && pwdata[`RRS_CTRL_CLRERR];
  wire [4:0] rec_len = word_reg[`RRS_LEN_HI:`RRS_LEN_LO];
  wire [4:0] rec_op = word_reg[`RRS_OP_HI:`RRS_OP_LO];
  wire op_known = (rec_op == `RRS_OP_START) || (rec_op == `RRS_OP_CHTYPE) ||
                  (rec_op == `RRS_OP_REFCLK) || (rec_op == `RRS_OP_CLOCK_GEN_BLOCK_SWITCH) ||
                  (rec_op == `RRS_OP_END);
  wire [31:0] addr_step = addr_mode_reg ? 32'h00000001 : 32'h00000002;
  reg ev_done;
  reg ev_err;
  reg [31:0] rd_mux;
  wire addr_ok = (paddr == `RRS_CTRL_OFF) || (paddr == `RRS_STATUS_OFF) ||
                 (paddr == `RRS_BASE_OFF) || (paddr == `RRS_DOFF_OFF) ||
                 (paddr == `RRS_DDATA_OFF) || (paddr == `RRS_ERR_OFF) ||
                 (paddr == `RRS_IRQ_ST_OFF) || (paddr == `RRS_IRQ_MASK_OFF) ||
                 (paddr == `RRS_CHTYPE_OFF);

  // Transceiver back-pressure is asynchronous
  rrs_sync2 u_wait_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(xcvr_wait_async),
    .q(xcvr_wait)
  );

  always @* begin
    case (paddr)
      `RRS_CTRL_OFF: rd_mux = {27'h0, addr_mode_reg, mode_reg, 2'h0};
      `RRS_STATUS_OFF: rd_mux = {30'h0, opcode_err_reg, busy};
      `RRS_BASE_OFF: rd_mux = base_reg;
      `RRS_DOFF_OFF: rd_mux = {21'h0, doff_reg};
      `RRS_DDATA_OFF: rd_mux = ddata_reg;
      `RRS_ERR_OFF: rd_mux = {30'h0, opcode_err_reg, 1'b0};
      `RRS_IRQ_ST_OFF: rd_mux = {30'h0, irq_st_reg};
      `RRS_IRQ_MASK_OFF: rd_mux = {30'h0, irq_mask_reg};
      `RRS_CHTYPE_OFF: rd_mux = {29'h0, chtype_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // APB slave: no wait states, pready high in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      mode_reg <= `RRS_MODE_STREAM;
      addr_mode_reg <= 1'b0;
      base_reg <= 32'h00000000;
      doff_reg <= 11'h000;
      ddata_reg <= 32'h00000000;
      irq_mask_reg <= 2'h0;
      irq_st_reg <= 2'h0;
      irq <= 1'b0;
    end else if (ce) begin
      pready <= setup;
      pslverr <= setup && !addr_ok;
      if (setup && !pwrite) begin
        prdata <= rd_mux;
      end
      if (wr_acc) begin
        case (paddr)
          `RRS_CTRL_OFF: begin
            mode_reg <= pwdata[`RRS_CTRL_MODE_HI:`RRS_CTRL_MODE_LO]; // see R1
            addr_mode_reg <= pwdata[`RRS_CTRL_ADDRMODE];
          end
          `RRS_BASE_OFF: base_reg <= pwdata;
          `RRS_DOFF_OFF: doff_reg <= pwdata[10:0];
          `RRS_DDATA_OFF: ddata_reg <= pwdata;
          `RRS_IRQ_MASK_OFF: irq_mask_reg <= pwdata[1:0];
          default: begin
          end
        endcase
      end
      // Sticky events, set wins over write-one clear
      irq_st_reg <= (irq_st_reg & ~((wr_acc && paddr == `RRS_IRQ_ST_OFF) ? pwdata[1:0] : 2'h0))
                    | {ev_err, ev_done};
      irq <= |(irq_st_reg & irq_mask_reg);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      busy <= 1'b0;
      img_addr <= 32'h00000000;
      img_rd <= 1'b0;
      xcvr_offset <= 11'h000;
      xcvr_wdata <= 32'h00000000;
      xcvr_wr <= 1'b0;
      opcode_err_reg <= 1'b0;
      chtype_reg <= `RRS_CHT_DUPLEX;
      word_reg <= 16'h0000;
      remain_reg <= 5'h00;
      woff_reg <= 11'h000;
      first_reg <= 1'b0;
      direct_req_reg <= 1'b0;
      ev_done <= 1'b0;
      ev_err <= 1'b0;
    end else if (ce) begin
      ev_done <= 1'b0;
      ev_err <= 1'b0;
      img_rd <= 1'b0;
      if (xcvr_wr && !xcvr_wait) begin
        xcvr_wr <= 1'b0;
      end
      if (clr_hit) begin
        opcode_err_reg <= 1'b0; // see R15
      end
      if (write_hit && mode_reg == `RRS_MODE_DIRECT) begin
        direct_req_reg <= 1'b1;
      end
      case (state_reg)
        S_IDLE: begin
          if (direct_req_reg && !xcvr_wr) begin
            direct_req_reg <= 1'b0;
            xcvr_offset <= doff_reg; // see R2
            xcvr_wdata <= ddata_reg;
            xcvr_wr <= 1'b1;
            state_reg <= S_DIRECT;
          end else if (start_hit && mode_reg == `RRS_MODE_STREAM &&
                       !opcode_err_reg && !clr_hit) begin // see R14 see R15
            busy <= 1'b1;
            img_addr <= base_reg;
            first_reg <= 1'b1;
            remain_reg <= 5'h00;
            state_reg <= S_FETCH;
          end
        end
        S_DIRECT: begin
          if (!xcvr_wr || !xcvr_wait) begin
            state_reg <= S_IDLE;
          end
        end
        S_FETCH: begin
          img_rd <= 1'b1; // see R3
          state_reg <= S_WAIT;
        end
        S_WAIT: begin
          if (img_rvalid) begin
            word_reg <= img_rdata; // see R4
            img_addr <= img_addr + addr_step; // see R16
            state_reg <= (remain_reg != 5'h00) ? S_WRITE : S_DECODE; // see R10
          end
        end
        S_DECODE: begin
          first_reg <= 1'b0;
          if (rec_len != 5'h00) begin // see R5
            woff_reg <= word_reg[`RRS_OFF_HI:`RRS_OFF_LO]; // see R9
            remain_reg <= rec_len;
            state_reg <= S_FETCH;
          end else if (!op_known || (first_reg && rec_op != `RRS_OP_START)) begin // see R13
            opcode_err_reg <= 1'b1;
            ev_err <= 1'b1;
            busy <= 1'b0;
            state_reg <= S_IDLE;
          end else if (rec_op == `RRS_OP_END) begin // see R6 see R7 see R17
            busy <= 1'b0;
            ev_done <= 1'b1;
            state_reg <= S_IDLE;
          end else begin
            if (rec_op == `RRS_OP_CHTYPE) begin
              chtype_reg <= word_reg[`RRS_CHT_HI:`RRS_CHT_LO]; // see R8
            end
            state_reg <= S_FETCH;
          end
        end
        S_WRITE: begin
          if (!xcvr_wr || !xcvr_wait) begin
            xcvr_offset <= woff_reg;
            xcvr_wdata <= {16'h0000, word_reg};
            xcvr_wr <= 1'b1;
            woff_reg <= woff_reg + 11'h001; // see R11
            remain_reg <= remain_reg - 5'h01;
            state_reg <= S_FETCH;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- dv/rrs_streamer_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module rrs_streamer_props (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [31:0] img_addr,
  input wire img_rd,
  input wire busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy;
    psel && !penable |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_pls;
    pready |=> !pready;
  endproperty
  a_pls: assert property (p_pls) else $error("long ready");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("lone error");
  property p_z;
    pready && pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  a_z: assert property (p_z) else $error("bad data");
  property p_rd;
    img_rd |=> !img_rd;
  endproperty
  a_rd: assert property (p_rd) else $error("long fetch");
  property p_own;
    img_rd |-> busy;
  endproperty
  a_own: assert property (p_own) else $error("idle fetch");
  property p_go;
    $rose(busy) |-> ##[0:4] img_rd;
  endproperty
  a_go: assert property (p_go) else $error("no fetch");
  property p_ce;
    !ce |=> $stable(img_addr) && $stable(busy);
  endproperty
  a_ce: assert property (p_ce) else $error("not frozen");
endmodule
bind rrs_streamer rrs_streamer_props u_rrs_streamer_props (.pclk(pclk),
  .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .img_addr(img_addr),
  .img_rd(img_rd), .busy(busy));
`default_nettype wire

// ---- dv/rrs_img_rom.sv ----
`timescale 1ns/100ps
`default_nettype none
module rrs_img_rom (
  input wire pclk,
  input wire presetn,
  input wire wm,
  input wire slow,
  input wire [31:0] img_addr,
  input wire img_rd,
  output logic [15:0] img_rdata,
  output logic img_rvalid
);
  logic [15:0] mem [0:15];
  logic [15:0] w;
  logic [1:0] n;
  // Answer after one or three cycles, junk between
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n <= 2'h0;
      img_rvalid <= 1'h0;
      img_rdata <= 16'h0;
    end else begin
      img_rvalid <= n == 2'h1;
      img_rdata <= n == 2'h1 ? w : ~img_rdata;
      if (img_rd) begin
        w <= mem[wm ? img_addr[3:0] : img_addr[4:1]];
        n <= slow ? 2'h3 : 2'h1;
      end else if (n != 2'h0) begin
        n <= n - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rrs_regs.vh"
module tb_top;
  logic pclk = 1'h0, presetn = 1'h0, ce = 1'h1, psel = 1'h0;
  logic penable = 1'h0, pwrite = 1'h0, wm = 1'h0, slow = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, img_addr, xcvr_wdata, r;
  logic [15:0] img_rdata;
  logic [10:0] xcvr_offset;
  logic pready, pslverr, img_rd, img_rvalid, xcvr_wr, busy, irq, e;
  logic [42:0] wq[$];
  int error_cnt = 0, check_count = 0, cyc = 0;
  initial forever #10 pclk = ~pclk;
  rrs_streamer u_rrs_streamer (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .img_addr(img_addr), .img_rd(img_rd), .img_rdata(img_rdata),
    .img_rvalid(img_rvalid), .xcvr_offset(xcvr_offset), .xcvr_wdata(xcvr_wdata),
    .xcvr_wr(xcvr_wr), .xcvr_wait_async(1'h0), .busy(busy), .irq(irq));
  rrs_img_rom u_rrs_img_rom (.pclk(pclk), .presetn(presetn), .wm(wm),
    .slow(slow), .img_addr(img_addr), .img_rd(img_rd), .img_rdata(img_rdata),
    .img_rvalid(img_rvalid));
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (xcvr_wr === 1'h1) wq.push_back({xcvr_offset, xcvr_wdata});
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish;
    end
  end
  task chk(input logic [42:0] g, input logic [42:0] x);
    check_count++;
    if (g !== x) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task run(input logic [31:0] c);
    int i;
    apb(1'h1, `RRS_CTRL_OFF, c);
    i = 0;
    while (busy !== 1'h0 && i < 400) begin
      @(posedge pclk);
      i++;
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    u_rrs_img_rom.mem = '{16'h0001, 16'h0062, 16'h0003, 16'h0004, 16'h1155,
      16'hA5A5, 16'h5A5A, 16'h0FFF, 16'h1234, 16'h001F, 16'h0, 16'h0, 16'h0,
      16'h0, 16'h0, 16'h0};
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, 12'h0FC, 32'h0);
    chk({r, e}, {32'h0, 1'h1});
    for (int m = 0; m < 2; m++) begin
      wm <= m[0];
      slow <= m[0];
      apb(1'h1, `RRS_BASE_OFF, 32'h0);
      run({27'h0, m[0], 4'h1});
      chk(wq.size(), 3);
      chk(wq.pop_front(), {11'h155, 32'h0000A5A5});
      chk(wq.pop_front(), {11'h156, 32'h00005A5A});
      chk(wq.pop_front(), {11'h7FF, 32'h00001234});
      apb(1'h0, `RRS_CHTYPE_OFF, 32'h0);
      chk(r, 3);
      apb(1'h0, `RRS_IRQ_ST_OFF, 32'h0);
      chk(r, 1);
      apb(1'h1, `RRS_IRQ_ST_OFF, 32'h3);
      $display("stream test %0d done", m);
    end
    u_rrs_img_rom.mem[0] = 16'h0005;
    apb(1'h1, `RRS_IRQ_MASK_OFF, 32'h2);
    run(32'h11);
    apb(1'h0, `RRS_STATUS_OFF, 32'h0);
    chk(r, 2);
    chk(irq, 1);
    u_rrs_img_rom.mem[0] = 16'h0001;
    run(32'h11);
    chk(wq.size(), 0);
    apb(1'h1, `RRS_CTRL_OFF, 32'h20);
    apb(1'h1, `RRS_IRQ_ST_OFF, 32'h3);
    @(posedge pclk);
    chk(irq, 0);
    run(32'h11);
    chk(wq.size(), 3);
    wq.delete();
    u_rrs_img_rom.mem[0] = 16'h0002;
    run(32'h11);
    apb(1'h0, `RRS_STATUS_OFF, 32'h0);
    chk(r, 2);
    chk(wq.size(), 0);
    apb(1'h1, `RRS_CTRL_OFF, 32'h20);
    u_rrs_img_rom.mem[0] = 16'h0001;
    $display("error test done");
    apb(1'h1, `RRS_CTRL_OFF, 32'h4);
    apb(1'h1, `RRS_DOFF_OFF, 32'h123);
    apb(1'h1, `RRS_DDATA_OFF, 32'hCAFE);
    apb(1'h1, `RRS_CTRL_OFF, 32'h6);
    repeat (6) @(posedge pclk);
    chk(wq.size(), 1);
    chk(wq.pop_front(), {11'h123, 32'h0000CAFE});
    ce <= 1'h0;
    repeat (3) @(posedge pclk);
    ce <= 1'h1;
    $display("direct test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
